/* File: shared/ddcss_pkg.sv */
// Constants, types and reset state for the DDC slave with start/stop filter
package ddcss_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADR_SETUP1 = 8'hD1;
  localparam logic [7:0] ADR_SETUP2 = 8'hD2;
  localparam logic [7:0] ADR_DDC_RAM_WINDOW = 8'hD4;
  localparam logic [7:0] ADR_D1DAT  = 8'hD5;
  localparam logic [7:0] ADR_PTR    = 8'hD6;
  localparam logic [7:0] ADR_DCON   = 8'hD7;
  localparam logic [7:0] ADR_S1CON  = 8'hD8;
  localparam logic [7:0] ADR_S1STA  = 8'hD9;
  localparam logic [7:0] ADR_S1DAT  = 8'hDA;
  localparam logic [7:0] ADR_S1ADR  = 8'hDB;
  // Reset values
  localparam logic [7:0] RST_SETUP  = 8'h00;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [3:0] RST_LINES  = 4'hF;
  localparam logic [3:0] RST_D1CNT  = 4'h8;
  // Field positions
  localparam int SETUP_EN   = 7;
  localparam int CON_EXDAT  = 6;
  localparam int CON_PER_BYTE_IRQ_SELECT  = 5;
  localparam int CON_AX     = 4;
  localparam int CON_D1INT  = 3;
  localparam int CON_D1EN   = 2;
  localparam int CON_SWHINT = 1;
  localparam int CON_MODE   = 0;
  localparam int S1CON_AA   = 2;
  localparam int ADR_GCEN   = 0;
  // Counts and codes
  localparam logic [3:0] I2C_BITS  = 4'h8;
  localparam logic [3:0] DDC1_BITS = 4'h8;
  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic [6:0] AX_MASK   = 7'h78;
  localparam logic [6:0] FULL_MASK = 7'h7F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX   = 3'b011,
    ST_DACK = 3'b100,
    ST_TX   = 3'b101,
    ST_TACK = 3'b110,
    ST_WAIT = 3'b111
  } ddcss_fsm_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ddcss_sfr_req_s;

  typedef struct packed {
    logic            phase;
    logic [3:0]      filt;
    logic [3:0]      prev;
    logic [3:0][7:0] fcnt;
    logic            ch2_start;
    logic            ch2_stop;
    logic [7:0]      setup1;
    logic [7:0]      setup2;
    logic [7:0]      d1dat;
    logic [7:0]      ptr;
    logic [7:0]      dcon;
    logic [7:0]      s1con;
    logic [7:0]      s1dat;
    logic [7:0]      s1adr;
    logic            serial_interrupt_flag;
    logic            stopf;
    logic            gcf;
    logic            txm;
    logic            nack;
    logic            slv;
    ddcss_fsm_e      fsm;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic            rw;
    logic            vs_prev;
    logic [3:0]      d1cnt;
    logic [7:0]      d1sh;
    logic            sda_oe;
    logic [7:0]      rdata;
  } ddcss_state_s;

  localparam ddcss_state_s RST_STATE = '{
    filt: RST_LINES, prev: RST_LINES, setup1: RST_SETUP,
    setup2: RST_SETUP, d1dat: RST_BYTE, ptr: RST_BYTE, dcon: RST_BYTE,
    fsm: ST_IDLE, d1cnt: RST_D1CNT, default: '0};
endpackage

/* File: verilog/ddcss_top.sv */
// DDC slave unit with RAM buffer, DDC1 sender and start/stop filters
// What this block does
// R01: Respond as slave when received address matches own bits 7:1 (bits 7:4 with wide match) or is a general call.
// R02: Reading the status register clears its interrupt flag automatically.
// R03: No interrupt flag for DDC2b transfers while auto serving is selected.
// R04: Hold setup bit 7 low: start/stop needs one sample, low bits ignored.
// R05: Hold setup bit 7 high: low bits plus one samples at half clock.
// R06: First hold setup register filters the DDC slave, resets to zero.
// R07: Second independent hold setup register filters the other I2C slave.
// R08: 256-byte RAM holds DDC data; the core loads it before hosts read.
// R09: Act only as slave; never start transfers nor drive the clock line.
// R10: Serve DDC1 and DDC2b data automatically without per-byte core work.
// R11: Optional per-byte interrupt lets the core supply each outgoing byte.
// R12: Data, clock and vertical sync arrive on port 4 bits 0, 1, 2.
// R13: Readable writable transmit byte register holds next DDC1 byte.
// R14: Channel control, status, data and address registers act as standard.
// R15: Select bit low fetches RAM at pointer; high interrupts core instead.
// R16: Buffer pointer increments after every RAM access, core or hardware; a pointer write in the same cycle replaces the step.
// R17: General call accepted only with address bit 0 set and acknowledge on.
// R18: Start/stop accepted once both lines hold new levels programmed samples.
`timescale 1ns/1ps
module ddcss_top (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  input  wire ddcss_pkg::ddcss_sfr_req_s sfr_i,
  output logic      [7:0]               sfr_rdata_o,
  input  wire logic [2:0]               p4_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  input  wire logic                     i2c2_sda_i,
  input  wire logic                     i2c2_scl_i,
  output logic                          i2c2_start_o,
  output logic                          i2c2_stop_o,
  output logic                          serial_interrupt_flag_o
);
  ddcss_pkg::ddcss_state_s q;
  ddcss_pkg::ddcss_state_s d;
  logic [7:0] ram [256];                 // [R08]
  logic [3:0] raw;
  logic [3:0][7:0] need;
  logic [7:0] ram_idx;
  logic [7:0] ram_q;
  logic [1:0] start;
  logic [1:0] stop;
  logic       scl_rise;
  logic       scl_fall;
  logic       aa;
  logic       per_byte_irq_select;
  logic       own_hit;
  logic       gc_hit;
  logic [6:0] mask;
  logic       core_ram;

  // Samples needed before a line change is believed
  function automatic logic [7:0] hold_need(input logic [7:0] setup);
    return setup[ddcss_pkg::SETUP_EN] ?
           ({1'b0, setup[6:0]} + 8'h01) : 8'h01; // [R04] [R05]
  endfunction

  // Line order: DDC sda, DDC scl, second channel sda, second channel scl
  assign raw  = {i2c2_scl_i, i2c2_sda_i, p4_i[1], p4_i[0]}; // [R12]
  assign need[0] = hold_need(q.setup1);  // [R06]
  assign need[1] = hold_need(q.setup1);
  assign need[2] = hold_need(q.setup2);  // [R07]
  assign need[3] = hold_need(q.setup2);

  // Conditions seen on the filtered lines only
  assign start[0] = q.prev[1] & q.filt[1] & q.prev[0] & ~q.filt[0]; // [R18]
  assign stop[0]  = q.prev[1] & q.filt[1] & ~q.prev[0] & q.filt[0];
  assign start[1] = q.prev[3] & q.filt[3] & q.prev[2] & ~q.filt[2];
  assign stop[1]  = q.prev[3] & q.filt[3] & ~q.prev[2] & q.filt[2];
  assign scl_rise = ~q.prev[1] & q.filt[1];
  assign scl_fall = q.prev[1] & ~q.filt[1];

  // Address decode; the optional wide match drops the low three bits
  assign aa      = q.s1con[ddcss_pkg::S1CON_AA];
  assign per_byte_irq_select   = q.dcon[ddcss_pkg::CON_PER_BYTE_IRQ_SELECT];
  assign mask    = q.dcon[ddcss_pkg::CON_AX] ? ddcss_pkg::AX_MASK
                                             : ddcss_pkg::FULL_MASK;
  assign own_hit = ((q.shreg[7:1] ^ q.s1adr[7:1]) & mask) == 7'h00; // [R01]
  assign gc_hit  = (q.shreg[7:1] == ddcss_pkg::GC_ADDR)
                   & q.s1adr[ddcss_pkg::ADR_GCEN];                  // [R17]

  // Small buffer mode folds the upper half onto the lower
  assign ram_idx  = {q.dcon[ddcss_pkg::CON_EXDAT] & q.ptr[7], q.ptr[6:0]};
  assign ram_q    = ram[ram_idx];
  assign core_ram = (sfr_i.wr | sfr_i.rd)
                    & (sfr_i.addr == ddcss_pkg::ADR_DDC_RAM_WINDOW);

  // Next state of everything except the RAM array
  always_comb begin
    logic       hw_inc;
    logic       ev;
    logic       ptr_wr;
    logic [7:0] ptr_val;
    logic [7:0] tx_byte;
    hw_inc  = 1'b0;
    ev      = 1'b0;
    ptr_wr  = 1'b0;
    ptr_val = q.ptr;
    tx_byte = per_byte_irq_select ? q.s1dat : ram_q;  // [R15] [R11]
    d = q;
    d.phase     = ~q.phase;
    d.prev      = q.filt;
    d.ch2_start = start[1];
    d.ch2_stop  = stop[1];
    d.vs_prev   = p4_i[2];

    // Hold filters step once per sample tick (half the clock)
    for (int l = 0; l < 4; l++) begin
      if (q.phase) begin
        if (raw[l] == q.filt[l]) begin
          d.fcnt[l] = 8'h00;
        end else if (q.fcnt[l] + 8'h01 >= need[l]) begin
          d.filt[l] = raw[l];           // [R04] [R05] [R18]
          d.fcnt[l] = 8'h00;
        end else begin
          d.fcnt[l] = q.fcnt[l] + 8'h01;
        end
      end
    end

    // Register writes from the core
    if (sfr_i.wr) begin
      unique case (sfr_i.addr)
        ddcss_pkg::ADR_SETUP1: d.setup1 = sfr_i.wdata;
        ddcss_pkg::ADR_SETUP2: d.setup2 = sfr_i.wdata;
        ddcss_pkg::ADR_D1DAT:  d.d1dat  = sfr_i.wdata;     // [R13]
        ddcss_pkg::ADR_PTR: begin
          ptr_wr  = 1'b1;
          ptr_val = sfr_i.wdata;
        end
        ddcss_pkg::ADR_DCON: begin
          // Event flags clear on a written zero; mode drops when disabled
          d.dcon[6:4] = sfr_i.wdata[6:4];
          d.dcon[ddcss_pkg::CON_D1EN] = sfr_i.wdata[ddcss_pkg::CON_D1EN];
          d.dcon[ddcss_pkg::CON_D1INT] =
            q.dcon[ddcss_pkg::CON_D1INT] & sfr_i.wdata[ddcss_pkg::CON_D1INT];
          d.dcon[ddcss_pkg::CON_SWHINT] =
            q.dcon[ddcss_pkg::CON_SWHINT] &
            sfr_i.wdata[ddcss_pkg::CON_SWHINT];
          d.dcon[ddcss_pkg::CON_MODE] =
            q.dcon[ddcss_pkg::CON_MODE] & sfr_i.wdata[ddcss_pkg::CON_D1EN];
        end
        ddcss_pkg::ADR_S1CON: d.s1con = sfr_i.wdata;        // [R14]
        ddcss_pkg::ADR_S1DAT: d.s1dat = sfr_i.wdata;
        ddcss_pkg::ADR_S1ADR: d.s1adr = sfr_i.wdata;        // [R01]
        default: ;
      endcase
    end

    // Register reads; status read clears the flag before any new set
    if (sfr_i.rd) begin
      unique case (sfr_i.addr)
        ddcss_pkg::ADR_SETUP1: d.rdata = q.setup1;
        ddcss_pkg::ADR_SETUP2: d.rdata = q.setup2;
        ddcss_pkg::ADR_DDC_RAM_WINDOW: d.rdata = ram_q;
        ddcss_pkg::ADR_D1DAT:  d.rdata = q.d1dat;
        ddcss_pkg::ADR_PTR:    d.rdata = q.ptr;
        ddcss_pkg::ADR_DCON:   d.rdata = {1'b0, q.dcon[6:0]};
        ddcss_pkg::ADR_S1CON:  d.rdata = q.s1con;
        ddcss_pkg::ADR_S1STA: begin
          d.rdata = {q.gcf, q.stopf, q.serial_interrupt_flag, q.txm, 2'b00, q.nack, q.slv};
          d.serial_interrupt_flag  = 1'b0;                                   // [R02]
        end
        ddcss_pkg::ADR_S1DAT:  d.rdata = q.s1dat;
        ddcss_pkg::ADR_S1ADR:  d.rdata = q.s1adr;
        default:               d.rdata = 8'h00;
      endcase
    end

    // DDC1 sender: each vertical sync rise shifts one bit, ninth is null
    if (q.dcon[ddcss_pkg::CON_D1EN] && !q.dcon[ddcss_pkg::CON_MODE] &&
        p4_i[2] && !q.vs_prev) begin                         // [R10]
      if (q.d1cnt == ddcss_pkg::DDC1_BITS) begin
        d.d1cnt  = 4'h0;
        d.sda_oe = 1'b0;
        d.d1sh   = q.d1dat;                                  // [R13]
        if (per_byte_irq_select) begin
          d.dcon[ddcss_pkg::CON_D1INT] = 1'b1;               // [R11]
        end else begin
          d.d1dat = ram_q;                                   // [R15]
          hw_inc  = 1'b1;
        end
      end else begin
        d.d1cnt  = q.d1cnt + 4'h1;
        d.sda_oe = ~q.d1sh[7];          // Open drain: drive only zeros
        d.d1sh   = {q.d1sh[6:0], 1'b0};
      end
    end

    // DDC2b slave; only SDA is ever driven, SCL is input only
    if (start[0]) begin
      d.fsm    = ddcss_pkg::ST_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
      if (!q.dcon[ddcss_pkg::CON_MODE]) begin
        d.dcon[ddcss_pkg::CON_MODE]   = 1'b1;
        d.dcon[ddcss_pkg::CON_SWHINT] = 1'b1;
      end
    end else if (stop[0]) begin
      if (q.slv) begin
        d.stopf = 1'b1;
        ev      = 1'b1;
      end
      d.slv    = 1'b0;
      d.txm    = 1'b0;
      d.sda_oe = 1'b0;
      d.fsm    = ddcss_pkg::ST_IDLE;
    end else begin
      unique case (q.fsm)
        ddcss_pkg::ST_IDLE, ddcss_pkg::ST_WAIT: ;
        ddcss_pkg::ST_ADDR, ddcss_pkg::ST_RX: begin
          if (scl_rise) begin
            d.shreg  = {q.shreg[6:0], q.filt[0]};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == ddcss_pkg::I2C_BITS) begin
            if (q.fsm == ddcss_pkg::ST_RX) begin
              // Host data byte becomes the buffer offset
              d.fsm    = ddcss_pkg::ST_DACK;
              d.sda_oe = aa;
              d.nack   = ~aa;
              d.s1dat  = q.shreg;
              ptr_wr   = 1'b1;
              ptr_val  = q.shreg;
              ev       = 1'b1;
            end else if (aa && (own_hit || gc_hit)) begin    // [R01] [R17]
              d.fsm    = ddcss_pkg::ST_AACK;
              d.sda_oe = 1'b1;
              d.slv    = 1'b1;
              d.rw     = q.shreg[0];
              d.txm    = q.shreg[0];
              d.gcf    = gc_hit;
              ev       = 1'b1;
            end else begin
              d.fsm = ddcss_pkg::ST_WAIT;
            end
          end
        end
        ddcss_pkg::ST_AACK, ddcss_pkg::ST_DACK: begin
          if (scl_fall) begin
            d.bitcnt = 4'h0;
            if (q.fsm == ddcss_pkg::ST_AACK && q.rw) begin
              d.shreg  = tx_byte;                            // [R15]
              d.sda_oe = ~tx_byte[7];
              d.fsm    = ddcss_pkg::ST_TX;
              hw_inc   = ~per_byte_irq_select;
            end else begin
              d.sda_oe = 1'b0;
              d.fsm    = ddcss_pkg::ST_RX;
            end
          end
        end
        ddcss_pkg::ST_TX: begin
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (q.bitcnt == ddcss_pkg::I2C_BITS) begin
              d.sda_oe = 1'b0;
              d.fsm    = ddcss_pkg::ST_TACK;
            end else begin
              d.shreg  = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
            end
          end
        end
        ddcss_pkg::ST_TACK: begin
          if (scl_rise) begin
            d.nack = q.filt[0];
            ev     = 1'b1;
            if (q.filt[0]) begin
              d.fsm = ddcss_pkg::ST_WAIT;
            end
          end else if (scl_fall) begin
            d.bitcnt = 4'h0;
            d.shreg  = tx_byte;                              // [R10]
            d.sda_oe = ~tx_byte[7];
            d.fsm    = ddcss_pkg::ST_TX;
            hw_inc   = ~per_byte_irq_select;
          end
        end
      endcase
    end

    // Flag set beats a same-cycle read clear; auto mode stays silent
    if (ev && per_byte_irq_select) begin
      d.serial_interrupt_flag = 1'b1;                                         // [R03] [R11]
    end
    if (ptr_wr) begin
      d.ptr = ptr_val;
    end else begin
      d.ptr = q.ptr + {7'h00, core_ram} + {7'h00, hw_inc};   // [R16]
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= ddcss_pkg::RST_STATE;                             // [R06]
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Buffer is written only by the core; no reset needed on data
  always_ff @(posedge clk_i) begin
    if (ce_i && sfr_i.wr && sfr_i.addr == ddcss_pkg::ADR_DDC_RAM_WINDOW) begin
      ram[ram_idx] <= sfr_i.wdata;                           // [R08]
    end
  end

  assign sfr_rdata_o             = q.rdata;
  assign sda_o                   = 1'b0;  // Open drain, low only [R09]
  assign sda_oe_o                = q.sda_oe;
  assign i2c2_start_o            = q.ch2_start;
  assign i2c2_stop_o             = q.ch2_stop;
  assign serial_interrupt_flag_o = q.serial_interrupt_flag;

  // Checks
  stat_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sfr_i.rd && sfr_i.addr == ddcss_pkg::ADR_S1STA && !d.serial_interrupt_flag
    |=> !q.serial_interrupt_flag) else $error("status read did not clear flag"); // [R02]
  auto_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.serial_interrupt_flag) |-> $past(per_byte_irq_select))
    else $error("flag raised in automatic mode");           // [R03]
  hold_one_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && q.phase && !q.setup1[ddcss_pkg::SETUP_EN] && raw[0] != q.filt[0]
    |=> q.filt[0] == $past(raw[0]))
    else $error("single sample hold not applied");          // [R04]
  hold_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(q.filt[0]) |->
    $past(q.fcnt[0]) + 8'h01 >= $past(need[0]))
    else $error("line accepted before hold count");         // [R05]
  setup_rst_a: assert property (@(posedge clk_i)
    $past(!rst_n_i) |-> q.setup1 == 8'h00 && q.fsm == ddcss_pkg::ST_IDLE)
    else $error("hold setup not zero after reset");         // [R06]
  slave_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    q.sda_oe && q.dcon[ddcss_pkg::CON_MODE] |->
    q.fsm inside {ddcss_pkg::ST_AACK, ddcss_pkg::ST_DACK, ddcss_pkg::ST_TX,
                  ddcss_pkg::ST_ADDR})
    else $error("data driven outside slave phases");        // [R09]
  ptr_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && core_ram && !sfr_i.wr && q.fsm == ddcss_pkg::ST_IDLE &&
    !(q.dcon[ddcss_pkg::CON_D1EN] && p4_i[2])
    |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("pointer did not step");                    // [R16]
  addr_match_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    q.fsm == ddcss_pkg::ST_AACK && $past(q.fsm) == ddcss_pkg::ST_ADDR |->
    $past(aa && (own_hit || gc_hit)))
    else $error("acknowledged foreign address");            // [R01]
  gc_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.gcf) |-> $past(q.s1adr[ddcss_pkg::ADR_GCEN] && aa))
    else $error("general call without enable");             // [R17]
  start_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    start[0]);
  tx_byte_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    q.fsm == ddcss_pkg::ST_TACK ##[1:400] q.fsm == ddcss_pkg::ST_TX);
  ddc1_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.dcon[ddcss_pkg::CON_D1INT]));
  stop_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.stopf));
endmodule // ddcss_top

/* File: bench/ddcss_host.sv */
// Behavioural DDC host driving the serial clock and open-drain data line
`timescale 1ns/1ps
module ddcss_host (
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int HALF = 16;
  logic sda_drv;
  // Pull-up on the wire: released by both parties it reads high
  assign sda_o = sda_drv & ~sda_oe_i;
  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end
  // Lines held for many samples so any short filter setting adopts them
  task automatic hold(input logic scl, input logic sda);
    @(posedge clk_i);
    scl_o <= scl;
    sda_drv <= sda;
    repeat (HALF) @(posedge clk_i);
  endtask
  // Clock parked low: data may toggle without forming a start
  task automatic park();
    hold(1'b0, 1'b1);
  endtask
  task automatic start();
    hold(scl_o, 1'b1);
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
    hold(1'b0, 1'b0);
  endtask
  task automatic stop();
    hold(1'b0, sda_drv);
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask
  // Data changes only in mid low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic seen);
    hold(1'b0, sda_drv);
    hold(1'b0, b);
    hold(1'b1, b);
    #1 seen = sda_o;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule // ddcss_host

/* File: bench/testbench.sv */
// Self-checking bench for the DDC slave unit and its start/stop filters
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ddcss_reg_row_s;
  typedef struct packed {
    logic [7:0] con;
    logic [7:0] adr;
    logic [7:0] dcon;
    logic [7:0] b;
    logic       ack;
  } ddcss_ack_row_s;
  typedef struct packed {
    logic [7:0]  s;
    logic [15:0] len;
    logic        e;
  } ddcss_filt_row_s;
  // Reset values first, then write and read back, unmapped and status register writes last
  localparam ddcss_reg_row_s REGS [11] = '{
    '{1'b0, 8'hD1, 8'h00, 8'h00}, '{1'b0, 8'hD5, 8'h00, 8'h00},
    '{1'b0, 8'hD6, 8'h00, 8'h00}, '{1'b0, 8'hD7, 8'h00, 8'h00},
    '{1'b1, 8'hD1, 8'h8B, 8'h8B}, '{1'b1, 8'hD1, 8'h00, 8'h00},
    '{1'b1, 8'hD2, 8'h83, 8'h83}, '{1'b1, 8'hD5, 8'hC3, 8'hC3},
    '{1'b1, 8'hDB, 8'hA0, 8'hA0}, '{1'b1, 8'hE0, 8'h5A, 8'h00},
    '{1'b1, 8'hD9, 8'hFF, 8'h00}};
  localparam ddcss_ack_row_s ACKS [7] = '{
    '{8'h04, 8'hA0, 8'h00, 8'hA0, 1'b1}, '{8'h04, 8'hA0, 8'h00, 8'hA2, 1'b0},
    '{8'h04, 8'hA1, 8'h00, 8'h00, 1'b1}, '{8'h04, 8'hA0, 8'h00, 8'h00, 1'b0},
    '{8'h00, 8'hA0, 8'h00, 8'hA0, 1'b0}, '{8'h04, 8'hA0, 8'h10, 8'hA6, 1'b1},
    '{8'h04, 8'hA0, 8'h00, 8'hA6, 1'b0}};
  // Glitch lengths in cycles; two cycles make one sample
  localparam ddcss_filt_row_s FILT [5] = '{
    '{8'h83, 16'h0005, 1'b0}, '{8'h83, 16'h0014, 1'b1},
    '{8'h7F, 16'h0003, 1'b1}, '{8'hFF, 16'h00C8, 1'b0},
    '{8'hFF, 16'h012C, 1'b1}};
  localparam logic [7:0] RAM [3] = '{8'h5A, 8'hA5, 8'h3C};
  localparam logic [7:0] B1 = 8'hC3;
  logic                      clk_i = 1'b0;
  logic                      rst_n_i = 1'b0;
  logic                      ce = 1'b1;
  logic                      vsync = 1'b0;
  logic                      i2c2_sda = 1'b1;
  logic                      scl, sda, sda_pin, sda_oe, flag, st2, sp2, a;
  logic [7:0]                rdata, v;
  ddcss_pkg::ddcss_sfr_req_s sfr = '0;
  int                        fails = 0;
  int                        check_count = 0;
  int                        n_start = 0;
  int                        n_stop = 0;
  int                        s0, p0;
  always #2.5 clk_i = ~clk_i;
  ddcss_top dut (
    .clk_i                   (clk_i),
    .rst_n_i                 (rst_n_i),
    .ce_i                    (ce),
    .sfr_i                   (sfr),
    .sfr_rdata_o             (rdata),
    .p4_i                    ({vsync, scl, sda}),
    .sda_o                   (sda_pin),
    .sda_oe_o                (sda_oe),
    .i2c2_sda_i              (i2c2_sda),
    .i2c2_scl_i              (1'b1),
    .i2c2_start_o            (st2),
    .i2c2_stop_o             (sp2),
    .serial_interrupt_flag_o (flag)
  );
  ddcss_host host (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  // Pulses last one cycle, so count them at every edge
  always @(posedge clk_i) begin
    if (st2 === 1'b1) n_start++;
    if (sp2 === 1'b1) n_stop++;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One access per call; an idle edge keeps calls from colliding
  task automatic sfr_op(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    sfr <= '{wr: w, rd: ~w, addr: ad, wdata: d};
    @(posedge clk_i);
    sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] q);
    sfr_op(1'b0, ad, 8'h00);
    #1 q = rdata;
  endtask
  task automatic vpulse(output logic oe);
    @(posedge clk_i) vsync <= 1'b1;
    repeat (12) @(posedge clk_i);
    #1 oe = sda_oe;
    @(posedge clk_i) vsync <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("rdata reset", 8'h00, rdata);
    chk("oe reset", 8'h00, {7'h0, sda_oe});
    chk("sda level", 8'h00, {7'h0, sda_pin});
    foreach (REGS[i]) begin
      if (REGS[i].w) sfr_op(1'b1, REGS[i].a, REGS[i].d);
      rd(REGS[i].a, v);
      chk("register", REGS[i].e, v);
    end
    // A write while the clock enable is low must not land
    @(posedge clk_i) ce <= 1'b0;
    sfr_op(1'b1, 8'hD1, 8'h55);
    ce <= 1'b1;
    rd(8'hD1, v);
    chk("frozen write", 8'h00, v);
    // Second channel filter: short glitches rejected, long ones kept
    foreach (FILT[i]) begin
      sfr_op(1'b1, 8'hD2, FILT[i].s);
      s0 = n_start;
      p0 = n_stop;
      @(posedge clk_i) i2c2_sda <= 1'b0;
      repeat (FILT[i].len) @(posedge clk_i);
      i2c2_sda <= 1'b1;
      repeat (600) @(posedge clk_i);
      chk("ch2 start", {7'h0, FILT[i].e}, 8'(n_start - s0));
      chk("ch2 stop", {7'h0, FILT[i].e}, 8'(n_stop - p0));
    end
    sfr_op(1'b1, 8'hD6, 8'h00);
    foreach (RAM[i]) sfr_op(1'b1, 8'hD4, RAM[i]);
    rd(8'hD6, v);
    chk("pointer", 8'h03, v);
    sfr_op(1'b1, 8'hD6, 8'h00);
    // Core read of the window returns the byte and steps the pointer
    rd(8'hD4, v);
    chk("ram read", RAM[0], v);
    rd(8'hD6, v);
    chk("pointer", 8'h01, v);
    sfr_op(1'b1, 8'hD6, 8'h00);
    // DDC1 with clock parked; first edge sends no bit, it loads the shifter and fetches the next byte from the buffer
    host.park();
    sfr_op(1'b1, 8'hD7, 8'h04);
    vpulse(a);
    for (int i = 7; i >= 0; i--) begin
      vpulse(a);
      chk("ddc1 bit", {7'h0, ~B1[i]}, {7'h0, a});
    end
    rd(8'hD5, v);
    chk("ddc1 next", RAM[0], v);
    rd(8'hD6, v);
    chk("pointer", 8'h01, v);
    foreach (ACKS[i]) begin
      sfr_op(1'b1, 8'hD8, ACKS[i].con);
      sfr_op(1'b1, 8'hDB, ACKS[i].adr);
      sfr_op(1'b1, 8'hD7, ACKS[i].dcon);
      host.start();
      host.send(ACKS[i].b, a);
      host.stop();
      chk("address ack", {7'h0, ACKS[i].ack}, {7'h0, a});
      chk("irq flag", 8'h00, {7'h0, flag});
    end
    // Automatic DDC2b read from the buffer
    sfr_op(1'b1, 8'hDB, 8'hA0);
    sfr_op(1'b1, 8'hD7, 8'h40);
    sfr_op(1'b1, 8'hD6, 8'h00);
    host.start();
    host.send(8'hA1, a);
    host.recv(1'b1, v);
    chk("ddc2b byte", RAM[0], v);
    host.recv(1'b0, v);
    chk("ddc2b byte", RAM[1], v);
    host.stop();
    rd(8'hD6, v);
    chk("pointer", 8'h02, v);
    chk("irq flag", 8'h00, {7'h0, flag});
    // Per-byte interrupt mode: flag raised, cleared by status read
    sfr_op(1'b1, 8'hD7, 8'h60);
    rd(8'hD9, v);
    host.start();
    host.send(8'hA0, a);
    chk("irq flag", 8'h01, {7'h0, flag});
    host.stop();
    rd(8'hD9, v);
    chk("status", 8'h60, v & 8'h60);
    rd(8'hD9, v);
    chk("status serial_interrupt_flag", 8'h00, v & 8'h20);
    sfr_op(1'b1, 8'hDA, 8'h77);
    host.start();
    host.send(8'hA1, a);
    host.recv(1'b0, v);
    host.stop();
    chk("irq byte", 8'h77, v);
    // Mid-run reset returns the setup register to zero
    sfr_op(1'b1, 8'hD1, 8'h85);
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'hD1, v);
    chk("setup reset", 8'h00, v);
    tally_and_finish();
  end
  // Whole run is some eleven thousand cycles; this is over five times that
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    $display("Error watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule // testbench
